// *** src/acs_pkg.sv ***
// Shared constants and carrier types for the converter back-end
package acs_pkg;
    localparam int          CHANNELS        = 6;
    localparam int          DATA_W          = 24;
    localparam int          CRC_W           = 16;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          MOD_SETTLE_CLKS = 8;
    localparam int          FAST_SAMPLES    = 2;
    localparam int          FRAME_WORDS     = 8;
    localparam int          GAIN_FRAC       = 23;
    localparam logic [23:0] OFFSET_RESET    = 24'h000000;
    localparam logic [23:0] GAIN_RESET      = 24'h800000;
    localparam logic [23:0] SAT_POS         = 24'h7FFFFF;
    localparam logic [23:0] SAT_NEG         = 24'h800000;
    localparam logic [15:0] POLY_CCITT      = 16'h1021;
    localparam logic [15:0] POLY_ANSI       = 16'h8005;
    localparam logic [15:0] CRC_SEED        = 16'hFFFF;
    localparam logic [15:0] CMD_NULL        = 16'h0000;
    localparam logic [15:0] CMD_RESET       = 16'h0011;
    localparam logic [2:0]  CMD_WRITE_TAG   = 3'h3;
    localparam int          CMD_TAG_LSB     = 13;
    localparam int          CMD_NREG_W      = 7;
    localparam int          CRC_WORD_LSB    = 8;
    localparam int          MAP_BITS        = 3 + 2 * CHANNELS * DATA_W;
    localparam int          MAP_IDX_W       = 9;

    typedef logic [CHANNELS-1:0][DATA_W-1:0] acs_conv_t;

    typedef struct packed {
        logic map_check_en;
        logic poly_ansi;
        logic rx_check_en;
    } acs_mode_t;

    typedef struct packed {
        logic [2:0]        ch;
        logic              is_gain;
        logic [DATA_W-1:0] value;
    } acs_coef_wr_t;

    typedef struct packed {
        logic check_error;
        logic map_changed;
    } acs_status_t;

    typedef enum logic [3:0] {
        ST_POR     = 4'h1,
        ST_WAITCLK = 4'h2,
        ST_SETTLE  = 4'h4,
        ST_RUN     = 4'h8
    } acs_state_t;
endpackage

// *** src/acs_crc16.sv ***
// Combinational 16-bit CRC update over one word, MSB first
`timescale 1ns/1ps
module acs_crc16 #(
    parameter int W = 24
) (
    input  wire logic [15:0]  crc_in,
    input  wire logic [W-1:0] data,
    input  wire logic         poly_ansi,
    output logic [15:0]       crc_out
);
    import acs_pkg::*;

    // Shift each data bit through the selected polynomial
    always_comb begin
        logic [15:0] c;
        logic [15:0] poly;
        logic        fb;
        c    = crc_in;
        poly = poly_ansi ? POLY_ANSI : POLY_CCITT;
        fb   = 1'b0;
        for (int i = W - 1; i >= 0; i--) begin
            fb = c[15] ^ data[i];
            c  = {c[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
        end
        crc_out = c;
    end
endmodule

// *** src/acs_backend.sv ***
// Calibration, start-up sequencing and frame / map check for the converter
// How it works
// - Subtract per-channel signed offset before output
// - Multiply by per-channel gain, 800000h unity
// - Always calibrate; offset 0, gain 800000h reset
// - Data-ready rises after power-on; ignore earlier traffic
// - Sample only after eight master clock periods
// - First two samples fast filter, then sinc3
// - Fast filter settles one period, sinc3 three
// - Other resets skip power-on, wait eight periods
// - Sixteen-bit check word covers whole frame
// - Optional input check, enabled by mode bit
// - Mismatch blocks commands except multi-register writes
// - Every mismatch sets check-error status flag
// - Every output frame ends with check word
// - One bit selects polynomial for all checks
// - Map check runs over writable map bits
// - One bit per master clock, flag on change
// - Map flag clears on status read or null
// - Any reset restores defaults, then converts
// - Long low sync pin resets until high
// - Reset command acts only on complete frame
`timescale 1ns/1ps
module acs_backend #(
    parameter int POR_TIME_NS       = 250000,
    parameter int RESET_LOW_TIME_NS = 2000
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 master_clock_in,
    input  wire logic                 sync_reset_n,
    input  wire logic                 conv_valid,
    input  wire acs_pkg::acs_conv_t   fast_data,
    input  wire acs_pkg::acs_conv_t   sinc_data,
    input  wire logic                 rx_word_valid,
    input  wire logic [23:0]          rx_word,
    input  wire logic                 rx_frame_done,
    input  wire logic                 tx_frame_start,
    input  wire logic                 tx_word_valid,
    input  wire logic [23:0]          tx_word,
    input  wire logic                 mode_wr,
    input  wire acs_pkg::acs_mode_t   mode_wdata,
    input  wire logic                 coef_wr,
    input  wire acs_pkg::acs_coef_wr_t coef_wdata,
    input  wire logic                 status_read,
    output acs_pkg::acs_conv_t        cal_data_q,
    output logic                      data_ready_n_q,
    output logic                      filter_feed_q,
    output logic                      cmd_go_q,
    output logic [15:0]               cmd_word_q,
    output acs_pkg::acs_mode_t        mode_q,
    output acs_pkg::acs_status_t      status_q,
    output logic [15:0]               map_check_value_q,
    output logic [15:0]               tx_check_word_q
);
    import acs_pkg::*;

    localparam int POR_CLKS = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RSL_CLKS = (RESET_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam logic [31:0] POR_LAST = 32'(POR_CLKS - 1);
    localparam logic [31:0] RSL_LAST = 32'(RSL_CLKS - 1);
    localparam logic [3:0]  SETTLE_LAST = 4'(MOD_SETTLE_CLKS - 1);
    localparam logic [3:0]  FRAME_LEN   = 4'(FRAME_WORDS);
    localparam logic [1:0]  FAST_LAST   = 2'(FAST_SAMPLES);
    localparam logic [MAP_IDX_W-1:0] MAP_LAST = MAP_IDX_W'(MAP_BITS - 1);

    // Synchronisers for the pin and the master clock
    logic mclk_s1_q, mclk_s2_q, mclk_s3_q;
    logic sr_s1_q, sr_s2_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mclk_s1_q <= 1'b0;
            mclk_s2_q <= 1'b0;
            mclk_s3_q <= 1'b0;
            sr_s1_q   <= 1'b1;
            sr_s2_q   <= 1'b1;
        end else begin
            mclk_s1_q <= master_clock_in;
            mclk_s2_q <= mclk_s1_q;
            mclk_s3_q <= mclk_s2_q;
            sr_s1_q   <= sync_reset_n;
            sr_s2_q   <= sr_s1_q;
        end
    end
    wire mclk_rise = mclk_s2_q & ~mclk_s3_q;

    // Pin reset: low longer than the reset width holds reset until high
    logic [31:0] low_cnt_q;
    logic        pin_rst_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_cnt_q <= 32'h00000000;
            pin_rst_q <= 1'b0;
        end else begin
            low_cnt_q <= sr_s2_q ? 32'h00000000 : (low_cnt_q + 32'h00000001);
            pin_rst_q <= ~sr_s2_q & (pin_rst_q | (low_cnt_q >= RSL_LAST));
        end
    end

    logic       cmd_rst_q;
    wire        soft_rst = pin_rst_q | cmd_rst_q;
    acs_state_t state_q, state_d;
    logic [31:0] por_cnt_q;
    logic [3:0]  settle_cnt_q;
    wire         por_done = (state_q != ST_POR);

    // Start-up sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_POR: begin
                if (por_cnt_q >= POR_LAST) state_d = ST_WAITCLK;
            end
            ST_WAITCLK: begin
                if (mclk_rise) state_d = ST_SETTLE;
            end
            ST_SETTLE: begin
                if (mclk_rise && settle_cnt_q == SETTLE_LAST) state_d = ST_RUN;
            end
            ST_RUN: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_POR;
            end
        endcase
        if (soft_rst && state_q != ST_POR) state_d = ST_WAITCLK;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q      <= ST_POR;
            por_cnt_q    <= 32'h00000000;
            settle_cnt_q <= 4'h0;
        end else begin
            state_q      <= state_d;
            por_cnt_q    <= (state_q == ST_POR) ? por_cnt_q + 32'h00000001 : por_cnt_q;
            settle_cnt_q <= (state_q != ST_SETTLE) ? 4'h0 :
                            (mclk_rise ? settle_cnt_q + 4'h1 : settle_cnt_q);
        end
    end

    // Configuration: mode bits and per-channel coefficients
    acs_conv_t offs_q, gain_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= '0;
            offs_q <= {CHANNELS{OFFSET_RESET}};
            gain_q <= {CHANNELS{GAIN_RESET}};
        end else if (soft_rst) begin
            mode_q <= '0;
            offs_q <= {CHANNELS{OFFSET_RESET}};
            gain_q <= {CHANNELS{GAIN_RESET}};
        end else begin
            if (mode_wr) mode_q <= mode_wdata;
            if (coef_wr && !coef_wdata.is_gain) offs_q[coef_wdata.ch] <= coef_wdata.value;
            if (coef_wr && coef_wdata.is_gain)  gain_q[coef_wdata.ch] <= coef_wdata.value;
        end
    end

    // Filter selection and calibration per channel
    logic [1:0] samp_cnt_q;
    wire        use_fast = (samp_cnt_q < FAST_LAST);
    wire        take     = conv_valid & (state_q == ST_RUN) & ~soft_rst;
    wire acs_conv_t cal_d;
    for (genvar g = 0; g < CHANNELS; g++) begin : g_cal
        wire signed [24:0] raw  = $signed({use_fast ? fast_data[g][23] : sinc_data[g][23],
                                           use_fast ? fast_data[g] : sinc_data[g]});
        wire signed [24:0] diff = raw - $signed({offs_q[g][23], offs_q[g]});
        wire signed [49:0] prod = diff * $signed({1'b0, gain_q[g]});
        wire signed [26:0] scl  = 27'(prod >>> GAIN_FRAC);
        wire               hi   = scl > $signed({3'b000, SAT_POS});
        wire               lo   = scl < $signed({3'b111, SAT_NEG});
        assign cal_d[g] = hi ? SAT_POS : (lo ? SAT_NEG : scl[23:0]);
    end

    // Output register and data-ready strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cal_data_q     <= '0;
            data_ready_n_q <= 1'b0;
            filter_feed_q  <= 1'b0;
            samp_cnt_q     <= 2'h0;
        end else begin
            filter_feed_q  <= (state_q == ST_RUN) & ~soft_rst;
            data_ready_n_q <= por_done & ~take;
            if (soft_rst) samp_cnt_q <= 2'h0;
            else if (take && use_fast) samp_cnt_q <= samp_cnt_q + 2'h1;
            if (take) cal_data_q <= cal_d;
        end
    end

    // Incoming frame: running check and command capture
    logic [15:0] rx_crc_q, rx_prev_q, rx_crc_d;
    logic [3:0]  word_cnt_q;
    logic [15:0] first_q;
    logic [23:0] last_q;
    acs_crc16 #(.W(24)) u_rx_crc (
        .crc_in    (rx_crc_q),
        .data      (rx_word),
        .poly_ansi (mode_q.poly_ansi),
        .crc_out   (rx_crc_d)
    );
    wire rx_take   = rx_word_valid & por_done;
    wire frame_end = rx_frame_done & por_done & (word_cnt_q != 4'h0);
    wire crc_match = (last_q[23:CRC_WORD_LSB] == rx_prev_q);
    wire crc_bad   = mode_q.rx_check_en & ~crc_match;
    wire is_multi  = (first_q[15:CMD_TAG_LSB] == CMD_WRITE_TAG) &
                     (first_q[CMD_NREG_W-1:0] != 7'h00);
    wire exec_ok   = frame_end & (~crc_bad | is_multi);
    wire is_null   = exec_ok & (first_q == CMD_NULL);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_crc_q   <= CRC_SEED;
            rx_prev_q  <= CRC_SEED;
            word_cnt_q <= 4'h0;
            first_q    <= 16'h0000;
            last_q     <= 24'h000000;
            cmd_go_q   <= 1'b0;
            cmd_word_q <= 16'h0000;
            cmd_rst_q  <= 1'b0;
        end else begin
            cmd_go_q  <= exec_ok;
            cmd_rst_q <= exec_ok & (first_q == CMD_RESET) & (word_cnt_q == FRAME_LEN);
            if (exec_ok) cmd_word_q <= first_q;
            if (rx_frame_done) begin
                rx_crc_q   <= CRC_SEED;
                rx_prev_q  <= CRC_SEED;
                word_cnt_q <= 4'h0;
            end else if (rx_take) begin
                rx_prev_q  <= rx_crc_q;
                rx_crc_q   <= rx_crc_d;
                last_q     <= rx_word;
                if (word_cnt_q == 4'h0) first_q <= rx_word[23:CRC_WORD_LSB];
                if (word_cnt_q != 4'hF) word_cnt_q <= word_cnt_q + 4'h1;
            end
        end
    end

    // Outgoing frame check word, restarted at each frame
    logic [15:0] tx_crc_d;
    acs_crc16 #(.W(24)) u_tx_crc (
        .crc_in    (tx_check_word_q),
        .data      (tx_word),
        .poly_ansi (mode_q.poly_ansi),
        .crc_out   (tx_crc_d)
    );
    always_ff @(posedge clk or posedge rst) begin
        if (rst) tx_check_word_q <= CRC_SEED;
        else if (tx_frame_start) tx_check_word_q <= CRC_SEED;
        else if (tx_word_valid) tx_check_word_q <= tx_crc_d;
    end

    // Map check: one bit per master clock rise, compared per pass
    wire [MAP_BITS-1:0] map_bits = {mode_q, offs_q, gain_q};
    logic [MAP_IDX_W-1:0] map_idx_q;
    logic [15:0]          map_crc_q, map_crc_d;
    logic                 map_have_q;
    acs_crc16 #(.W(1)) u_map_crc (
        .crc_in    (map_crc_q),
        .data      (map_bits[MAP_LAST - map_idx_q]),
        .poly_ansi (mode_q.poly_ansi),
        .crc_out   (map_crc_d)
    );
    wire map_step = mode_q.map_check_en & mclk_rise & ~soft_rst;
    wire map_end  = map_step & (map_idx_q == MAP_LAST);
    wire map_diff = map_end & map_have_q & (map_crc_d != map_check_value_q);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            map_idx_q         <= '0;
            map_crc_q         <= CRC_SEED;
            map_check_value_q <= 16'h0000;
            map_have_q        <= 1'b0;
        end else if (soft_rst || !mode_q.map_check_en) begin
            map_idx_q  <= '0;
            map_crc_q  <= CRC_SEED;
            map_have_q <= map_have_q & ~soft_rst;
            if (soft_rst) map_check_value_q <= 16'h0000;
        end else if (map_step) begin
            map_idx_q <= map_end ? '0 : map_idx_q + 9'h001;
            map_crc_q <= map_end ? CRC_SEED : map_crc_d;
            if (map_end) begin
                map_check_value_q <= map_crc_d;
                map_have_q        <= 1'b1;
            end
        end
    end

    // Status flags: a new event wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_q <= '0;
        end else if (soft_rst) begin
            status_q <= '0;
        end else begin
            status_q.check_error <= (frame_end & crc_bad) |
                                    (status_q.check_error & ~status_read);
            status_q.map_changed <= map_diff |
                                    (status_q.map_changed & ~status_read & ~is_null);
        end
    end
endmodule

// *** dv/acs_host_model.sv ***
// Host-side pin model: master clock and dual-function sync pin
`timescale 1ns/1ps
module acs_host_model (
    input  wire logic run,
    input  wire logic pin_low,
    output logic      master_clock_in,
    output logic      sync_reset_n
);
    // Master clock, 80 ns period, held low while stopped
    initial master_clock_in = 1'b0;
    always #40 master_clock_in = run ? ~master_clock_in : 1'b0;
    // Pin is driven high unless the host asks for a reset
    assign sync_reset_n = ~pin_low;
endmodule

// *** dv/acs_backend_sva.sv ***
// Port-level checker for the converter back-end
`timescale 1ns/1ps
module acs_backend_sva #(
    parameter int RESET_LOW_TIME_NS = 2000
) (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 conv_valid,
    input wire logic                 rx_frame_done,
    input wire logic                 tx_frame_start,
    input wire logic                 tx_word_valid,
    input wire logic                 mode_wr,
    input wire acs_pkg::acs_mode_t   mode_wdata,
    input wire logic                 status_read,
    input wire logic                 sync_reset_n,
    input wire acs_pkg::acs_conv_t   cal_data_q,
    input wire logic                 data_ready_n_q,
    input wire logic                 filter_feed_q,
    input wire logic                 cmd_go_q,
    input wire acs_pkg::acs_mode_t   mode_q,
    input wire acs_pkg::acs_status_t status_q,
    input wire logic [15:0]          tx_check_word_q
);
    import acs_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Pin low run length; the feed must be off a few cycles past the reset width
    localparam int PIN_LIMIT = (RESET_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 6;
    logic [31:0] low_run_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) low_run_q <= 32'h00000000;
        else low_run_q <= sync_reset_n ? 32'h00000000 : (low_run_q + 32'h00000001);
    end
    // Ready pulses only follow a taken sample, one cycle low
    a_ready_from_sample: assert property ($fell(data_ready_n_q) |-> $past(conv_valid))
        else $error("ready fell without a sample");
    a_ready_one_low: assert property ($fell(data_ready_n_q) && !conv_valid |=> data_ready_n_q)
        else $error("ready low longer than one cycle");
    a_cal_holds: assert property (data_ready_n_q && $past(data_ready_n_q) |-> $stable(cal_data_q))
        else $error("result changed without ready");
    // Commands only at the end of a frame, one cycle long
    a_cmd_from_done: assert property (cmd_go_q |-> $past(rx_frame_done))
        else $error("command without frame end");
    a_cmd_single: assert property (cmd_go_q |=> !cmd_go_q)
        else $error("command pulse too long");
    // Mode write, error flag keeping and output check word restart
    a_mode_written: assert property (mode_wr && sync_reset_n && !cmd_go_q
        |=> mode_q == $past(mode_wdata))
        else $error("mode write lost");
    a_err_holds: assert property (status_q.check_error && !status_read && !cmd_go_q
        && sync_reset_n |=> status_q.check_error)
        else $error("check error flag lost");
    a_tx_restart: assert property (tx_frame_start && !tx_word_valid
        |=> tx_check_word_q == CRC_SEED)
        else $error("output check word not restarted");
    // Long low pin stops the filter feed
    a_pin_stops_feed: assert property (low_run_q >= 32'(PIN_LIMIT) |-> !filter_feed_q)
        else $error("feed active during pin reset");
endmodule
bind acs_backend acs_backend_sva #(.RESET_LOW_TIME_NS(RESET_LOW_TIME_NS))
    acs_backend_sva_inst (.clk, .rst, .conv_valid, .rx_frame_done,
    .tx_frame_start, .tx_word_valid, .mode_wr, .mode_wdata, .status_read, .sync_reset_n,
    .cal_data_q, .data_ready_n_q, .filter_feed_q, .cmd_go_q, .mode_q, .status_q,
    .tx_check_word_q);

// *** dv/tb.sv ***
// Self-checking bench for the converter back-end
`timescale 1ns/1ps
module tb;
    import acs_pkg::*;
    logic clk = 1'b0, rst = 1'b1, run = 1'b0, pin_low = 1'b0;
    logic conv_valid, rx_word_valid, rx_frame_done, tx_frame_start, tx_word_valid;
    logic mode_wr, coef_wr, status_read, master_clock_in, sync_reset_n;
    logic data_ready_n_q, filter_feed_q, cmd_go_q;
    logic [23:0] rx_word, tx_word;
    logic [15:0] cmd_word_q, map_check_value_q, tx_check_word_q;
    acs_conv_t fast_data, sinc_data, cal_data_q;
    acs_mode_t mode_wdata, mode_q;
    acs_coef_wr_t coef_wdata;
    acs_status_t status_q;
    logic [31:0] seed = 32'h93152C54;
    logic [23:0] off [CHANNELS], gn [CHANNELS];
    int err_total = 0, check_count = 0, go_cnt = 0, mrise = 0;

    acs_host_model acs_host_model_inst (.run(run), .pin_low(pin_low),
        .master_clock_in(master_clock_in), .sync_reset_n(sync_reset_n));
    acs_backend #(.POR_TIME_NS(500), .RESET_LOW_TIME_NS(100)) acs_backend_inst (
        .clk(clk), .rst(rst), .master_clock_in(master_clock_in), .sync_reset_n(sync_reset_n),
        .conv_valid(conv_valid), .fast_data(fast_data), .sinc_data(sinc_data),
        .rx_word_valid(rx_word_valid), .rx_word(rx_word), .rx_frame_done(rx_frame_done),
        .tx_frame_start(tx_frame_start), .tx_word_valid(tx_word_valid), .tx_word(tx_word),
        .mode_wr(mode_wr), .mode_wdata(mode_wdata), .coef_wr(coef_wr), .coef_wdata(coef_wdata),
        .status_read(status_read), .cal_data_q(cal_data_q), .data_ready_n_q(data_ready_n_q),
        .filter_feed_q(filter_feed_q), .cmd_go_q(cmd_go_q), .cmd_word_q(cmd_word_q),
        .mode_q(mode_q), .status_q(status_q), .map_check_value_q(map_check_value_q),
        .tx_check_word_q(tx_check_word_q));

    // Clock, command and master clock edge counters
    always #5 clk = ~clk;
    always @(negedge clk) if (cmd_go_q === 1'b1) go_cnt++;
    always @(posedge master_clock_in) mrise++;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Check word update over one 24-bit word, MSB first
    function automatic logic [15:0] crc(input logic [15:0] c, input logic [23:0] d, input bit a);
        logic fb;
        for (int i = 23; i >= 0; i--) begin
            fb = c[15] ^ d[i];
            c = {c[14:0], 1'b0} ^ (fb ? (a ? POLY_ANSI : POLY_CCITT) : 16'h0000);
        end
        return c;
    endfunction
    // Offset, gain and saturation of one channel
    function automatic logic [23:0] cal(input logic [23:0] x, o, g);
        logic signed [49:0] p;
        p = (($signed({x[23], x}) - $signed({o[23], o})) * $signed({1'b0, g})) >>> GAIN_FRAC;
        if (p > 50'sh7FFFFF) return SAT_POS;
        if (p < -50'sh800000) return SAT_NEG;
        return p[23:0];
    endfunction
    // Map check over mode, offsets ch5..0 and gains ch5..0, one bit at a time
    function automatic logic [15:0] mapcrc(input logic [2:0] m, input bit a);
        logic [MAP_BITS-1:0] b;
        logic [15:0] c;
        b = MAP_BITS'(m);
        for (int i = CHANNELS - 1; i >= 0; i--) b = {b[MAP_BITS-25:0], off[i]};
        for (int i = CHANNELS - 1; i >= 0; i--) b = {b[MAP_BITS-25:0], gn[i]};
        c = CRC_SEED;
        for (int i = MAP_BITS - 1; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? (a ? POLY_ANSI : POLY_CCITT) : 16'h0000);
        return c;
    endfunction

    task automatic chk(input string n, input logic [47:0] e, input logic [47:0] s);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic sample(input bit s, input logic [23:0] corner);
        for (int c = 0; c < CHANNELS; c++) begin
            fast_data[c] = (c == 0) ? corner : 24'(rnd());
            sinc_data[c] = (c == 0) ? ~corner : 24'(rnd());
        end
        conv_valid = 1'b1;
        cyc(1);
        conv_valid = 1'b0;
        chk("ready_low", 0, data_ready_n_q);
        for (int c = 0; c < CHANNELS; c++)
            chk("cal", cal(s ? sinc_data[c] : fast_data[c], off[c], gn[c]), cal_data_q[c]);
        cyc(1);
    endtask
    task automatic setcoef(input int ch, input bit g, input logic [23:0] v);
        coef_wdata = {3'(ch), g, v};
        coef_wr = 1'b1;
        if (g) gn[ch] = v;
        else off[ch] = v;
        cyc(1);
        coef_wr = 1'b0;
        cyc(1);
    endtask
    task automatic setmode(input logic [2:0] m);
        mode_wdata = m;
        mode_wr = 1'b1;
        cyc(1);
        mode_wr = 1'b0;
    endtask
    task automatic pulse_read();
        status_read = 1'b1;
        cyc(1);
        status_read = 1'b0;
    endtask
    task automatic frame(input logic [15:0] cmd, input int n, input bit bad, input bit a);
        logic [15:0] c;
        logic [23:0] w;
        c = CRC_SEED;
        for (int i = 0; i < n; i++) begin
            w = (i == 0) ? {cmd, 8'h00} : 24'(rnd());
            if (i == n - 1) w = {c ^ {15'h0000, bad}, 8'h00};
            else c = crc(c, w, a);
            rx_word = w;
            rx_word_valid = 1'b1;
            cyc(1);
        end
        rx_word_valid = 1'b0;
        rx_frame_done = 1'b1;
        cyc(1);
        rx_frame_done = 1'b0;
        cyc(3);
    endtask
    task automatic txchk(input bit a);
        logic [15:0] c;
        c = CRC_SEED;
        tx_frame_start = 1'b1;
        cyc(1);
        tx_frame_start = 1'b0;
        for (int i = 0; i < 3; i++) begin
            tx_word = 24'(rnd());
            c = crc(c, tx_word, a);
            tx_word_valid = 1'b1;
            cyc(1);
            chk("tx_crc", c, tx_check_word_q);
        end
        tx_word_valid = 1'b0;
    endtask
    // Defaults back, settle wait, then fast, fast, sinc3
    task automatic restart();
        int m0, k;
        cyc(2);
        chk("feed_off", 0, filter_feed_q);
        chk("mode_dflt", 0, mode_q);
        for (int c = 0; c < CHANNELS; c++) begin
            off[c] = OFFSET_RESET;
            gn[c] = GAIN_RESET;
        end
        m0 = mrise;
        for (k = 0; k < 3000 && filter_feed_q !== 1'b1; k++) cyc(1);
        chk("mod_settle", 1, mrise - m0 >= 8);
        sample(0, 24'h7FFFFF);
        sample(0, 24'h000001);
        sample(1, 24'h800000);
        $display("restart test done");
    endtask

    // Watchdog
    initial begin
        #300us;
        err_total++;
        conclude();
    end

    initial begin
        int g0;
        {conv_valid, rx_word_valid, rx_frame_done, tx_frame_start, tx_word_valid} = '0;
        {mode_wr, coef_wr, status_read} = '0;
        {fast_data, sinc_data, rx_word, tx_word, mode_wdata, coef_wdata} = '0;
        cyc(5);
        rst = 1'b0;
        frame(CMD_NULL, 1, 0, 0);
        chk("early_go", 0, go_cnt);
        for (g0 = 0; g0 < 300 && data_ready_n_q !== 1'b1; g0++) cyc(1);
        chk("por_wait", 1, g0 >= 40);
        run = 1'b1;
        restart();
        for (int k = 0; k < 8; k++) begin
            setcoef(k % CHANNELS, k / CHANNELS, 24'(rnd()));
            sample(1, 24'(rnd()));
        end
        setcoef(0, 1, 24'hFFFFFF);
        setcoef(0, 0, 24'h800000);
        sample(1, 24'h800000);
        setcoef(0, 0, 24'h7FFFFF);
        sample(1, 24'h7FFFFF);
        $display("calibration test done");
        for (int a = 0; a < 2; a++) begin
            setmode({1'b0, a[0], 1'b1});
            g0 = go_cnt;
            frame(CMD_NULL, FRAME_WORDS, 0, a[0]);
            chk("go_good", g0 + 1, go_cnt);
            chk("cmd_word", CMD_NULL, cmd_word_q);
            frame(CMD_NULL, FRAME_WORDS, 1, a[0]);
            chk("go_bad", g0 + 1, go_cnt);
            chk("crc_err", 1, status_q.check_error);
            pulse_read();
            chk("err_clr", 0, status_q.check_error);
            frame({CMD_WRITE_TAG, 13'h0002}, FRAME_WORDS, 1, a[0]);
            chk("go_multi", g0 + 2, go_cnt);
            chk("crc_err2", 1, status_q.check_error);
            pulse_read();
            txchk(a[0]);
        end
        $display("frame check test done");
        setmode(3'h6);
        frame(CMD_RESET, FRAME_WORDS - 1, 0, 1);
        chk("short_reset", 3'h6, mode_q);
        frame(CMD_RESET, FRAME_WORDS, 0, 1);
        restart();
        setcoef(1, 1, 24'h400000);
        setmode(3'h1);
        pin_low = 1'b1;
        cyc(30);
        chk("pin_mode", 0, mode_q);
        pin_low = 1'b0;
        cyc(5);
        restart();
        setmode(3'h4);
        cyc(7500);
        pulse_read();
        cyc(2500);
        chk("map_same", 0, status_q.map_changed);
        chk("map_value", mapcrc(3'h4, 1'b0), map_check_value_q);
        setcoef(2, 0, 24'(rnd()) | 24'h000001);
        cyc(7500);
        chk("map_diff", 1, status_q.map_changed);
        frame(CMD_NULL, FRAME_WORDS, 0, 0);
        chk("map_null", 0, status_q.map_changed);
        $display("map check test done");
        conclude();
    end
endmodule
